/* File: core/vkcv_debounce.sv */
// Key debouncer with press-edge pulse
`timescale 1ns/10ps
`include "vkcv_regs.svh"
module vkcv_debounce #(
    parameter int CNT_MAX = `VKCV_DEBOUNCE_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic key_n_in,
    output logic pressed_out,
    output logic press_pulse_out
);
    typedef struct packed {
        logic stable;
        logic [31:0] cnt;
        logic pulse;
    } vkcv_deb_t;
    vkcv_deb_t s_q, s_d;

    // Count while raw level differs from stable level, accept after CNT_MAX
    always_comb begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        if ((~key_n_in) == s_q.stable) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= 32'(CNT_MAX - 1)) begin
            s_d.cnt = '0;
            s_d.stable = ~key_n_in;
            s_d.pulse = ~key_n_in;
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pressed_out = s_q.stable;
    assign press_pulse_out = s_q.pulse;

    one_pulse_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        press_pulse_out |=> !press_pulse_out) else $error("press pulse longer than one cycle");
endmodule

/* File: core/vkcv_key_ctrl.sv */
// Key-driven playback control, volume stepping and serial mode select
`timescale 1ns/10ps
`include "vkcv_regs.svh"
module vkcv_key_ctrl
    import vkcv_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `VKCV_DEBOUNCE_CYC,
    parameter int NUM_KEYS = 6
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic direct_mode_en_in,
    input wire logic build_two_wire_in,
    input wire logic sel_pulled_low_in,
    input wire logic voice_done_in,
    input wire logic key_play_next_voice_n_in,
    input wire logic key_play_next_sentence_n_in,
    input wire logic key_stop_n_in,
    input wire logic key_rewind_first_n_in,
    input wire logic key_volume_up_n_in,
    input wire logic key_volume_down_n_in,
    output logic playing_out,
    output logic [7:0] voice_cmd_out,
    output logic [7:0] sentence_out,
    output logic [3:0] volume_level_out,
    output logic [7:0] volume_cmd_out,
    output logic [3:0] output_drive_level_out,
    output logic mute_out,
    output logic two_wire_mode_out,
    output logic cmd_strobe_out
);
    logic [NUM_KEYS-1:0] key_n;
    logic [NUM_KEYS-1:0] press;

    typedef struct packed {
        vkcv_play_t play;
        logic [6:0] voice;
        logic [7:0] sentence;
        logic [3:0] vol;
        logic [3:0] drive;
        logic two_wire;
        logic strobe;
    } vkcv_state_t;
    vkcv_state_t s_q, s_d;

    // Keys gathered low-active in a vector
    assign key_n = {key_volume_down_n_in, key_volume_up_n_in, key_rewind_first_n_in,
                    key_stop_n_in, key_play_next_sentence_n_in, key_play_next_voice_n_in};

    // One debouncer per key
    genvar gi;
    generate
        for (gi = 0; gi < NUM_KEYS; gi++) begin : g_key
            vkcv_debounce #(.CNT_MAX(DEBOUNCE_CYC)) u_deb (
                .core_clk_in(core_clk_in),
                .reset_n_in(reset_n_in),
                .key_n_in(key_n[gi]),
                .pressed_out(),
                .press_pulse_out(press[gi])
            );
        end
    endgenerate

    // Drive-level field for a volume level; codes 1010B and 1101B skipped
    function automatic logic [3:0] drive_of(input logic [3:0] lvl);
        logic [3:0] r;
        r = 4'h0;
        if (lvl >= 4'hC) begin
            case (lvl)
                4'hC: r = 4'hB;
                4'hD: r = 4'hC;
                4'hE: r = 4'hE;
                default: r = 4'hF;
            endcase
        end else if (lvl >= 4'h2) begin
            r = lvl - 4'h2;
        end
        return r;
    endfunction

    // Key actions and playback state
    always_comb begin
        s_d = s_q;
        s_d.strobe = 1'b0;
        // Serial mode: pulled-low select pin swaps the built-in choice
        s_d.two_wire = build_two_wire_in ^ sel_pulled_low_in;
        if (s_q.play == VKCV_PLAY && voice_done_in) begin
            s_d.play = VKCV_IDLE;
        end
        if (direct_mode_en_in) begin
            if (press[0]) begin
                s_d.strobe = 1'b1;
                if (s_q.play == VKCV_PLAY) begin
                    s_d.voice = (s_q.voice == `VKCV_VOICE_LAST) ? `VKCV_VOICE_FIRST
                                : s_q.voice + 7'h01;
                end
                s_d.play = VKCV_PLAY;
            end else if (press[1]) begin
                s_d.strobe = 1'b1;
                if (s_q.play == VKCV_PLAY) begin
                    s_d.sentence = s_q.sentence + 8'h01;
                end
                s_d.play = VKCV_PLAY;
            end else if (press[2]) begin
                s_d.play = VKCV_STOPPED;
                s_d.strobe = 1'b1;
            end else if (press[3]) begin
                s_d.voice = `VKCV_VOICE_FIRST;
                s_d.sentence = `VKCV_SENT_FIRST;
                s_d.strobe = 1'b1;
            end
            if (press[4] && !press[5] && s_q.vol != `VKCV_VOL_MAX) begin
                s_d.vol = s_q.vol + 4'h1;
            end else if (press[5] && !press[4] && s_q.vol != `VKCV_VOL_MIN) begin
                s_d.vol = s_q.vol - 4'h1;
            end
        end
        s_d.drive = drive_of(s_d.vol);
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            s_q.play <= VKCV_IDLE;
            s_q.voice <= `VKCV_VOICE_FIRST;
            s_q.sentence <= `VKCV_SENT_FIRST;
            s_q.vol <= `VKCV_VOL_RESET;
            s_q.drive <= `VKCV_DRIVE_RESET;
            s_q.two_wire <= 1'b0;
            s_q.strobe <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign playing_out = (s_q.play == VKCV_PLAY);
    assign voice_cmd_out = {1'b0, s_q.voice};
    assign sentence_out = s_q.sentence;
    assign volume_level_out = s_q.vol;
    assign volume_cmd_out = `VKCV_VOL_CMD_BASE | {4'h0, s_q.vol};
    assign mute_out = (s_q.vol == `VKCV_VOL_MIN);
    assign output_drive_level_out = s_q.drive;
    assign two_wire_mode_out = s_q.two_wire;
    assign cmd_strobe_out = s_q.strobe;

    // Volume stepping and saturation
    vol_up_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[4] && !press[5] && volume_level_out != 4'hF
        |=> volume_level_out == $past(volume_level_out) + 4'h1) else $error("volume up");
    vol_dn_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[5] && !press[4] && volume_level_out != 4'h1
        |=> volume_level_out == $past(volume_level_out) - 4'h1) else $error("volume down");
    vol_saturate_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        volume_level_out >= 4'h1) else $error("volume below level 1");
    vol_top_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[4] && volume_level_out == 4'hF
        |=> volume_level_out == 4'hF) else $error("volume passed level 15");
    vol_bottom_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[5] && volume_level_out == 4'h1
        |=> volume_level_out == 4'h1) else $error("volume passed level 1");

    // Command code, drive table and mute
    mute_level_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        mute_out == (volume_cmd_out == 8'hE1)) else $error("mute mismatch");
    vol_code_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        volume_cmd_out[7:4] == 4'hE && volume_cmd_out[3:0] == volume_level_out)
        else $error("volume command code");
    drive_low_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        volume_level_out inside {[4'h2:4'hB]} |->
        output_drive_level_out == volume_level_out - 4'h2) else $error("drive level");
    drive_high_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        volume_level_out >= 4'hC |-> output_drive_level_out ==
            ((volume_level_out == 4'hC) ? 4'hB :
            (volume_level_out == 4'hD) ? 4'hC : volume_level_out))
        else $error("drive table high");
    drive_skip_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        output_drive_level_out != 4'hA && output_drive_level_out != 4'hD)
        else $error("unused drive code");

    // Play, skip, stop and rewind keys
    play_key_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[0] |=> playing_out && cmd_strobe_out)
        else $error("play key ignored");
    next_voice_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[0] && playing_out
        |=> voice_cmd_out[6:0] == $past(voice_cmd_out[6:0]) + 7'h01)
        else $error("next voice");
    sentence_key_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[1] && !press[0] |=> playing_out && cmd_strobe_out)
        else $error("sentence key ignored");
    next_sentence_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[1] && !press[0] && playing_out
        |=> sentence_out == $past(sentence_out) + 8'h01) else $error("next sentence");
    stop_key_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[2] && !press[1] && !press[0] |=> !playing_out)
        else $error("stop ignored");
    rewind_key_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        direct_mode_en_in && press[3] && press[2:0] == 3'b000 |=> voice_cmd_out == 8'h00)
        else $error("rewind failed");
    voice_range_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        voice_cmd_out <= 8'h7F) else $error("voice code out of range");

    // Key enable, strobe source and serial mode
    strobe_keys_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        cmd_strobe_out |-> $past(direct_mode_en_in) && $past(press[3:0]) != 4'h0)
        else $error("strobe without key");
    keys_disabled_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        !direct_mode_en_in |=> $stable(volume_level_out)) else $error("keys acted");
    mode_swap_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ##1 two_wire_mode_out == ($past(build_two_wire_in) ^ $past(sel_pulled_low_in)))
        else $error("mode select");
endmodule

/* File: core/vkcv_pkg.sv */
// Types for the key-driven playback control block
package vkcv_pkg;
    typedef enum logic [2:0] {
        VKCV_IDLE = 3'b001,
        VKCV_PLAY = 3'b010,
        VKCV_STOPPED = 3'b100
    } vkcv_play_t;
endpackage

/* File: core/vkcv_regs.svh */
// Constants for the key-driven playback control block
`ifndef VKCV_REGS_SVH
`define VKCV_REGS_SVH
`define VKCV_DEBOUNCE_US 20000
`define VKCV_CLK_MHZ 10
`define VKCV_DEBOUNCE_CYC (`VKCV_DEBOUNCE_US * `VKCV_CLK_MHZ)
`define VKCV_VOL_MIN 4'h1
`define VKCV_VOL_MAX 4'hF
`define VKCV_VOL_RESET 4'h8
`define VKCV_DRIVE_RESET 4'h6
`define VKCV_VOL_CMD_BASE 8'hE0
`define VKCV_VOICE_FIRST 7'h00
`define VKCV_VOICE_LAST 7'h7F
`define VKCV_SENT_FIRST 8'h00
`endif

/* File: testbench/vkcv_key_model.sv */
// Push-button and select pull-down model
`timescale 1ns/10ps
module vkcv_key_model (
    input wire logic core_clk_in,
    input wire logic [5:0] hold_in,
    input wire logic pd_fitted_in,
    output logic [5:0] key_n_out,
    output logic sel_pulled_low_out
);
    logic [5:0] h1 = 6'h00;
    logic [5:0] h2 = 6'h00;
    initial key_n_out = 6'h3F;
    // Contacts chatter once on press, then sit low while held
    always @(posedge core_clk_in) begin
        h1 <= hold_in;
        h2 <= h1;
        key_n_out <= ~hold_in | (h1 & ~h2);
    end
    assign sel_pulled_low_out = pd_fitted_in;
endmodule

/* File: testbench/voice_key_control_volume_tb_top.sv */
// Self-checking bench for the key-driven playback control
`timescale 1ns/10ps
module voice_key_control_volume_tb_top;
    localparam int DB = 4;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic en = 1'b1, b2 = 1'b0, pd = 1'b0, done = 1'b0;
    logic [5:0] hold = 6'h00, key_n;
    logic sel, play, strb, mute, two;
    logic [7:0] voice, sent, vcmd;
    logic [3:0] lvl, drv;
    logic [15:0] n_strb = 16'h0000, e_strb = 16'h0000;
    logic e_play = 1'b0, e_two = 1'b0;
    logic [7:0] e_voice = 8'h00, e_sent = 8'h00;
    logic [3:0] e_lvl = 4'h8;
    logic [50:0] exp_q[$];
    int bad_count = 0, checks = 0, cycles = 0;
    event note_ev;
    vkcv_key_model i_keys (.core_clk_in(core_clk_in), .hold_in(hold), .pd_fitted_in(pd),
        .key_n_out(key_n), .sel_pulled_low_out(sel));
    vkcv_key_ctrl #(.DEBOUNCE_CYC(DB)) i_dut (.core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in), .direct_mode_en_in(en), .build_two_wire_in(b2),
        .sel_pulled_low_in(sel), .voice_done_in(done),
        .key_play_next_voice_n_in(key_n[0]), .key_play_next_sentence_n_in(key_n[1]),
        .key_stop_n_in(key_n[2]), .key_rewind_first_n_in(key_n[3]),
        .key_volume_up_n_in(key_n[4]), .key_volume_down_n_in(key_n[5]),
        .playing_out(play), .voice_cmd_out(voice), .sentence_out(sent),
        .volume_level_out(lvl), .volume_cmd_out(vcmd), .output_drive_level_out(drv),
        .mute_out(mute), .two_wire_mode_out(two), .cmd_strobe_out(strb));
    // Clock, strobe tally and hang guard
    always #50 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        if (strb === 1'b1) n_strb <= n_strb + 16'h0001;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [50:0] seen, input logic [50:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [3:0] drive_of(input logic [3:0] l);
        if (l < 4'hC) return l - 4'h2;
        return (l == 4'hC) ? 4'hB : (l == 4'hD) ? 4'hC : l;
    endfunction
    // Driver notes the expected state once outputs have settled
    task automatic note;
        @(negedge core_clk_in);
        exp_q.push_back({e_strb, e_two, e_play, e_voice, e_sent, e_lvl, 8'hE0 | {4'h0, e_lvl},
            (e_lvl == 4'h1) ? 4'h0 : drive_of(e_lvl), e_lvl == 4'h1});
        -> note_ev;
    endtask
    // Press and release a key; expectation follows the enable seen at the press edge
    task automatic key(input int k);
        @(posedge core_clk_in) hold <= 6'h01 << k;
        if (en) begin
            if (k < 4) e_strb = e_strb + 16'h0001;
            case (k)
                0: if (e_play) e_voice = (e_voice + 8'h01) & 8'h7F; else e_play = 1'b1;
                1: if (e_play) e_sent = e_sent + 8'h01; else e_play = 1'b1;
                2: e_play = 1'b0;
                3: {e_voice, e_sent} = 16'h0000;
                4: if (e_lvl != 4'hF) e_lvl = e_lvl + 4'h1;
                default: if (e_lvl != 4'h1) e_lvl = e_lvl - 4'h1;
            endcase
        end
        repeat (DB + 8) @(posedge core_clk_in);
        hold <= 6'h00;
        repeat (DB + 8) @(posedge core_clk_in);
        note();
    endtask
    // Watcher compares each appearing result with the oldest note
    initial forever begin
        @(note_ev);
        check({n_strb, two, play, voice, sent, lvl, vcmd, mute ? 4'h0 : drv, mute},
            exp_q.pop_front());
    end
    initial begin
        void'($urandom(32'h0c15));
        repeat (10) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        note();
        key(0); key(0); key(1); key(2); key(3); key(0);
        // Playback engine ends the voice; play key then restarts from idle
        @(posedge core_clk_in) done <= 1'b1;
        @(posedge core_clk_in) done <= 1'b0;
        e_play = 1'b0;
        note();
        key(0);
        for (int i = 0; i < 8; i++) key(4);
        for (int i = 0; i < 15; i++) key(5);
        for (int i = 0; i < 24; i++) key(4 + int'($urandom % 2));
        @(posedge core_clk_in) en <= 1'b0;
        key(4); key(0); key(2);
        @(posedge core_clk_in) en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_in) {b2, pd} <= 2'(i);
            e_two = i[1] ^ i[0];
            repeat (3) @(posedge core_clk_in);
            note();
        end
        // Mid-run reset restores reset values; keys act right after release
        @(posedge core_clk_in) reset_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        {e_play, e_voice, e_sent, e_lvl} = {1'b0, 8'h00, 8'h00, 4'h8};
        repeat (3) @(posedge core_clk_in);
        note();
        key(5);
        key(0);
        repeat (2) @(posedge core_clk_in);
        give_verdict();
    end
endmodule
